// [hdl/gdb_bus_core.sv]
`timescale 1ns/1ps
// Overview of operation
// - Primary address is programmable, only 0 to 30 accepted.
// - Primary address is 14 after reset.
// - Remote entered only by own listen address while REN asserted.
// - Talker addressing works in both remote and local state.
// - In remote, panel keys ignored; local key returns to local unless locked out.
// - Interface clear idles talker and listener and their indicators.
// - Interface clear leaves settings and stored data untouched.
// - Lockout disables all keys and the local key.
// - Go-to-local, while listener addressed, returns to local and lifts lockout.
// - Device clear pulses the flush of buffers and pending commands.
// - Device clear leaves settings and stored data untouched.
// - Universal device clear acts whether addressed or not.
// - Selective device clear acts only while listener addressed.
// - Group trigger acts only when bus trigger source is selected.
// - Serial poll returns status byte when talker with serial poll enabled.
// - Talker active on own talk address; idle on untalk, listen, clear.
// - Listener active on own listen address; idle on unlisten, talk.
// - Service request holds until polled or its condition clears.
module gdb_bus_core
  import gdb_pkg::*;
#(
  parameter int NKEYS = 8
)
(
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic [7:0] CMD_IN,
  input wire logic CMD_VALID_IN,
  input wire logic IFC_IN,
  input wire logic REN_IN,
  input wire logic POLL_REQ_IN,
  input wire logic SRQ_COND_IN,
  input wire logic [NKEYS-1:0] KEYS_IN,
  input wire logic LOCAL_KEY_IN,
  output logic [NKEYS-1:0] KEYS_OUT,
  output logic REMOTE_STATE_INDICATOR_OUT,
  output logic TALK_INDICATOR_OUT,
  output logic LISTENER_ACTIVE_INDICATOR_OUT,
  output logic LOCKOUT_OUT,
  output logic SRQ_OUT,
  output logic [7:0] POLL_BYTE_OUT,
  output logic POLL_VALID_OUT,
  output logic DEV_CLEAR_OUT,
  output logic TRIGGER_OUT
);

  gdb_cmd_if cmd_bus();

  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] wr_off_reg;
  logic [7:0] wr_off_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [4:0] addr_reg;
  logic [4:0] addr_next;
  logic trig_bus_reg;
  logic trig_bus_next;
  logic [7:0] stb_reg;
  logic [7:0] stb_next;
  logic acc;

  gdb_tlk_t tlk_reg;
  gdb_tlk_t tlk_next;
  gdb_lsn_t lsn_reg;
  gdb_lsn_t lsn_next;
  logic rem_reg;
  logic rem_next;
  logic llo_reg;
  logic llo_next;
  logic spe_reg;
  logic spe_next;
  logic srq_reg;
  logic srq_next;
  logic cond_d_reg;
  logic cond_d_next;
  logic [NKEYS-1:0] keys_reg;
  logic [NKEYS-1:0] keys_next;
  logic [7:0] poll_byte_reg;
  logic [7:0] poll_byte_next;
  logic poll_valid_reg;
  logic poll_valid_next;
  logic clr_reg;
  logic clr_next;
  logic trg_reg;
  logic trg_next;
  logic poll_hit;

  // Command byte decoder
  gdb_cmd_dec u_dec (
    .clk_in(SYS_CLK_IN),
    .rstn_in(RSTN_IN),
    .cmd_in(CMD_IN),
    .valid_in(CMD_VALID_IN),
    .addr_in(addr_reg),
    .dec(cmd_bus)
  );

  // Register read mux, unmapped offsets read zero
  function automatic logic [31:0] read_word(input logic [7:0] off);
    read_word = '0;
    case (off)
      OFF_CFG:
      begin
        read_word[4:0] = addr_reg;
        read_word[CFG_TRIG_BIT] = trig_bus_reg;
      end
      OFF_STAT:
      begin
        read_word[ST_REM_BIT] = rem_reg;
        read_word[ST_LLO_BIT] = llo_reg;
        read_word[ST_TLK_BIT] = (tlk_reg == TLK_ACTIVE);
        read_word[ST_LSN_BIT] = (lsn_reg == LSN_ACTIVE);
        read_word[ST_SPE_BIT] = spe_reg;
        read_word[ST_SRQ_BIT] = srq_reg;
      end
      OFF_STB: read_word[7:0] = stb_reg;
      default: read_word = '0;
    endcase
  endfunction : read_word

  // Bus slave: address phase capture and data phase write
  always_comb
  begin
    acc = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    wr_pend_next = acc && HWRITE_IN;
    wr_off_next = acc ? HADDR_IN[7:0] : wr_off_reg;
    hrdata_next = hrdata_reg;
    addr_next = addr_reg;
    trig_bus_next = trig_bus_reg;
    stb_next = stb_reg;
    if (acc && !HWRITE_IN)
      hrdata_next = read_word(HADDR_IN[7:0]);
    if (wr_pend_reg)
    begin
      case (wr_off_reg)
        OFF_CFG:
        begin
          if (HWDATA_IN[4:0] <= ADDR_MAX)
            addr_next = HWDATA_IN[4:0];
          trig_bus_next = HWDATA_IN[CFG_TRIG_BIT];
        end
        OFF_STB: stb_next = HWDATA_IN[7:0];
        default: stb_next = stb_reg;
      endcase
    end
  end

  // Bus slave and configuration registers
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      wr_pend_reg <= 1'b0;
      wr_off_reg <= '0;
      hrdata_reg <= '0;
      addr_reg <= ADDR_RESET;
      trig_bus_reg <= 1'b0;
      stb_reg <= STB_RESET;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      wr_off_reg <= wr_off_next;
      hrdata_reg <= hrdata_next;
      addr_reg <= addr_next;
      trig_bus_reg <= trig_bus_next;
      stb_reg <= stb_next;
    end
  end

  assign HRDATA_OUT = hrdata_reg;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  // Interface function states; clears never touch configuration
  always_comb
  begin
    poll_hit = POLL_REQ_IN && spe_reg && (tlk_reg == TLK_ACTIVE);
    tlk_next = tlk_reg;
    lsn_next = lsn_reg;
    rem_next = rem_reg;
    llo_next = llo_reg;
    spe_next = spe_reg;
    srq_next = srq_reg;
    cond_d_next = SRQ_COND_IN;
    // Listener and talker addressing, independent of remote
    if (cmd_bus.ev.mla)
      lsn_next = LSN_ACTIVE;
    if (cmd_bus.ev.unl || cmd_bus.ev.mta)
      lsn_next = LSN_IDLE;
    if (cmd_bus.ev.mta)
      tlk_next = TLK_ACTIVE;
    if (cmd_bus.ev.unt || cmd_bus.ev.mla || cmd_bus.ev.ota)
      tlk_next = TLK_IDLE;
    if (IFC_IN)
    begin
      tlk_next = TLK_IDLE;
      lsn_next = LSN_IDLE;
      spe_next = 1'b0;
    end
    // Remote and lockout
    if (REN_IN && cmd_bus.ev.mla)
      rem_next = 1'b1;
    if (LOCAL_KEY_IN && rem_reg && !llo_reg)
      rem_next = 1'b0;
    if (cmd_bus.ev.gtl && lsn_reg == LSN_ACTIVE)
    begin
      rem_next = 1'b0;
      llo_next = 1'b0;
    end
    if (cmd_bus.ev.llo)
      llo_next = 1'b1;
    if (!REN_IN)
    begin
      rem_next = 1'b0;
      llo_next = 1'b0;
    end
    // Serial poll mode
    if (cmd_bus.ev.spe)
      spe_next = 1'b1;
    if (cmd_bus.ev.spd)
      spe_next = 1'b0;
    // Service request: a new condition edge beats a clear
    if (!SRQ_COND_IN || poll_hit)
      srq_next = 1'b0;
    if (SRQ_COND_IN && !cond_d_reg)
      srq_next = 1'b1;
  end

  // Interface state registers
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      tlk_reg <= TLK_IDLE;
      lsn_reg <= LSN_IDLE;
      rem_reg <= 1'b0;
      llo_reg <= 1'b0;
      spe_reg <= 1'b0;
      srq_reg <= 1'b0;
      cond_d_reg <= 1'b0;
    end
    else
    begin
      tlk_reg <= tlk_next;
      lsn_reg <= lsn_next;
      rem_reg <= rem_next;
      llo_reg <= llo_next;
      spe_reg <= spe_next;
      srq_reg <= srq_next;
      cond_d_reg <= cond_d_next;
    end
  end

  // Key gating, clear and trigger pulses, poll byte
  always_comb
  begin
    keys_next = (rem_reg || llo_reg) ? '0 : KEYS_IN;
    clr_next = cmd_bus.ev.dcl ||
      (cmd_bus.ev.sdc && lsn_reg == LSN_ACTIVE);
    trg_next = cmd_bus.ev.get && trig_bus_reg;
    poll_valid_next = poll_hit;
    poll_byte_next = poll_byte_reg;
    if (poll_hit)
    begin
      poll_byte_next = stb_reg;
      poll_byte_next[STB_RQS_BIT] = srq_reg;
    end
  end

  // Output registers
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      keys_reg <= '0;
      clr_reg <= 1'b0;
      trg_reg <= 1'b0;
      poll_valid_reg <= 1'b0;
      poll_byte_reg <= '0;
    end
    else
    begin
      keys_reg <= keys_next;
      clr_reg <= clr_next;
      trg_reg <= trg_next;
      poll_valid_reg <= poll_valid_next;
      poll_byte_reg <= poll_byte_next;
    end
  end

  assign KEYS_OUT = keys_reg;
  assign REMOTE_STATE_INDICATOR_OUT = rem_reg;
  assign TALK_INDICATOR_OUT = (tlk_reg == TLK_ACTIVE);
  assign LISTENER_ACTIVE_INDICATOR_OUT = (lsn_reg == LSN_ACTIVE);
  assign LOCKOUT_OUT = llo_reg;
  assign SRQ_OUT = srq_reg;
  assign POLL_BYTE_OUT = poll_byte_reg;
  assign POLL_VALID_OUT = poll_valid_reg;
  assign DEV_CLEAR_OUT = clr_reg;
  assign TRIGGER_OUT = trg_reg;

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  sequence s_listen_remote;
    REN_IN ##0 cmd_bus.ev.mla;
  endsequence

  property p_addr_range;
    addr_reg <= ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("primary address out of range");

  property p_rem_cause;
    $rose(rem_reg) |-> $past(REN_IN) && $past(cmd_bus.ev.mla);
  endproperty
  a_rem_cause: assert property (p_rem_cause)
    else $error("remote entered without listen address and REN");

  property p_rem_enter;
    s_listen_remote |=> rem_reg;
  endproperty
  a_rem_enter: assert property (p_rem_enter)
    else $error("remote not entered");

  property p_local_key;
    LOCAL_KEY_IN && rem_reg && !llo_reg && !cmd_bus.ev.mla
      |=> !rem_reg ##1 keys_reg == KEYS_IN || rem_reg || llo_reg
      || $changed(KEYS_IN);
  endproperty
  a_local_key: assert property (p_local_key)
    else $error("local key did not return to local");

  property p_ifc_idle;
    IFC_IN |=> !TALK_INDICATOR_OUT && !LISTENER_ACTIVE_INDICATOR_OUT;
  endproperty
  a_ifc_idle: assert property (p_ifc_idle)
    else $error("interface clear left talker or listener active");

  property p_ifc_keep;
    IFC_IN && !wr_pend_reg |=> $stable(addr_reg) && $stable(stb_reg);
  endproperty
  a_ifc_keep: assert property (p_ifc_keep)
    else $error("interface clear altered settings");

  property p_llo_keys;
    llo_reg |=> KEYS_OUT == '0;
  endproperty
  a_llo_keys: assert property (p_llo_keys)
    else $error("keys passed during lockout");

  property p_gtl;
    cmd_bus.ev.gtl && lsn_reg == LSN_ACTIVE |=> !rem_reg && !llo_reg;
  endproperty
  a_gtl: assert property (p_gtl)
    else $error("go to local not obeyed");

  property p_dcl;
    cmd_bus.ev.dcl |=> DEV_CLEAR_OUT ##1
      (!DEV_CLEAR_OUT || $past(cmd_bus.ev.dcl || cmd_bus.ev.sdc));
  endproperty
  a_dcl: assert property (p_dcl)
    else $error("device clear pulse wrong");

  property p_sdc_unaddr;
    cmd_bus.ev.sdc && lsn_reg == LSN_IDLE |=> !DEV_CLEAR_OUT;
  endproperty
  a_sdc_unaddr: assert property (p_sdc_unaddr)
    else $error("selective clear acted while not addressed");

  property p_get;
    cmd_bus.ev.get |=> TRIGGER_OUT == $past(trig_bus_reg);
  endproperty
  a_get: assert property (p_get)
    else $error("trigger does not follow source selection");

  property p_poll;
    poll_hit |=> POLL_VALID_OUT &&
      POLL_BYTE_OUT[STB_RQS_BIT] == $past(srq_reg);
  endproperty
  a_poll: assert property (p_poll)
    else $error("serial poll byte not returned");

  property p_talk;
    cmd_bus.ev.mta && !IFC_IN |=> TALK_INDICATOR_OUT &&
      !LISTENER_ACTIVE_INDICATOR_OUT;
  endproperty
  a_talk: assert property (p_talk)
    else $error("own talk address not obeyed");

  property p_srq_hold;
    srq_reg && SRQ_COND_IN && !poll_hit |=> srq_reg;
  endproperty
  a_srq_hold: assert property (p_srq_hold)
    else $error("service request dropped early");

endmodule : gdb_bus_core

// [hdl/gdb_cmd_dec.sv]
`timescale 1ns/1ps
module gdb_cmd_dec
  import gdb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] cmd_in,
  input wire logic valid_in,
  input wire logic [4:0] addr_in,
  gdb_cmd_if.dec dec
);

  gdb_cmd_t hit_reg;
  gdb_cmd_t hit_next;

  // Address group match against a given address
  function automatic logic grp_hit(input logic [7:0] b,
    input logic [1:0] g, input logic [4:0] a);
    grp_hit = (b[6:5] == g) && (b[4:0] == a);
  endfunction : grp_hit

  // Decode one command byte against the live address
  always_comb
  begin
    hit_next = '0;
    if (valid_in)
    begin
      hit_next.mla = grp_hit(cmd_in, GRP_LISTEN, addr_in);
      hit_next.mta = grp_hit(cmd_in, GRP_TALK, addr_in);
      hit_next.ota = (cmd_in[6:5] == GRP_TALK) &&
        (cmd_in[4:0] != addr_in) && (cmd_in[4:0] != ADDR_NONE);
      hit_next.unl = (cmd_in[6:0] == CMD_UNL);
      hit_next.unt = (cmd_in[6:0] == CMD_UNT);
      hit_next.gtl = (cmd_in[6:0] == CMD_GTL);
      hit_next.sdc = (cmd_in[6:0] == CMD_SDC);
      hit_next.get = (cmd_in[6:0] == CMD_GET);
      hit_next.llo = (cmd_in[6:0] == CMD_LLO);
      hit_next.dcl = (cmd_in[6:0] == CMD_DCL);
      hit_next.spe = (cmd_in[6:0] == CMD_SPE);
      hit_next.spd = (cmd_in[6:0] == CMD_SPD);
    end
  end

  // Register the pulses
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      hit_reg <= '0;
    else
      hit_reg <= hit_next;
  end

  assign dec.ev = hit_reg;

  property p_own_listen;
    @(posedge clk_in) disable iff (!rstn_in)
    valid_in && cmd_in[6:5] == GRP_LISTEN && cmd_in[4:0] == addr_in
      |=> hit_reg.mla;
  endproperty
  a_own_listen: assert property (p_own_listen)
    else $error("own listen address not decoded");

endmodule : gdb_cmd_dec

// [shared/gdb_cmd_if.sv]
`timescale 1ns/1ps
// Decoded command pulses from decoder to core
interface gdb_cmd_if;
  import gdb_pkg::*;
  gdb_cmd_t ev;
  modport dec (output ev);
  modport core (input ev);
endinterface : gdb_cmd_if

// [shared/gdb_pkg.sv]
package gdb_pkg;
  // Bus command codes, compared on the low seven data lines
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  // Address groups in bits 6:5 and the reserved address
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [4:0] ADDR_NONE = 5'h1F;
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  localparam logic [4:0] ADDR_RESET = 5'h0E;
  // Register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_STB = 8'h08;
  // Field positions
  localparam int CFG_TRIG_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int ST_REM_BIT = 0;
  localparam int ST_LLO_BIT = 1;
  localparam int ST_TLK_BIT = 2;
  localparam int ST_LSN_BIT = 3;
  localparam int ST_SPE_BIT = 4;
  localparam int ST_SRQ_BIT = 5;
  localparam logic [7:0] STB_RESET = 8'h00;
  // Controller's least interface clear width
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_IFC_MIN_NS = 100000;
  localparam int IFC_MIN_CYC = (T_IFC_MIN_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;

  typedef enum logic {TLK_IDLE, TLK_ACTIVE} gdb_tlk_t;
  typedef enum logic {LSN_IDLE, LSN_ACTIVE} gdb_lsn_t;

  // One-cycle pulses of decoded bus commands
  typedef struct packed {
    logic mla;
    logic mta;
    logic ota;
    logic unl;
    logic unt;
    logic gtl;
    logic sdc;
    logic get;
    logic llo;
    logic dcl;
    logic spe;
    logic spd;
  } gdb_cmd_t;
endpackage : gdb_pkg

// [verif/gdb_ctl_model.sv]
`timescale 1ns/1ps
// Bus controller on the far side, driving command bytes and lines
module gdb_ctl_model
  import gdb_pkg::*;
(
  input wire logic clk_in,
  output logic [7:0] cmd_out,
  output logic valid_out,
  output logic ifc_out,
  output logic ren_out,
  output logic poll_out
);
  // Idle bus at time zero
  initial
  begin
    cmd_out = 8'h00;
    valid_out = 1'b0;
    ifc_out = 1'b0;
    ren_out = 1'b0;
    poll_out = 1'b0;
  end
  // One byte; a released line shows the inverse, never the old value
  task send(input logic [7:0] b);
    @(posedge clk_in);
    cmd_out <= b;
    valid_out <= 1'b1;
    @(posedge clk_in);
    valid_out <= 1'b0;
    cmd_out <= ~b;
  endtask : send
  // Remote enable level
  task set_ren(input logic v);
    @(posedge clk_in);
    ren_out <= v;
  endtask : set_ren
  // Interface clear held the least width of 1000 cycles
  task ifc;
    @(posedge clk_in);
    ifc_out <= 1'b1;
    repeat (IFC_MIN_CYC) @(posedge clk_in);
    ifc_out <= 1'b0;
  endtask : ifc
  // Controller reads one byte from the talker
  task poll;
    @(posedge clk_in);
    poll_out <= 1'b1;
    @(posedge clk_in);
    poll_out <= 1'b0;
  endtask : poll
endmodule : gdb_ctl_model

// [verif/gpib_device_bus_functions_tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the device bus functions
module gpib_device_bus_functions_tb;
  import gdb_pkg::*;
  typedef struct packed {logic [7:0] wr; logic [7:0] exp;} gdb_row_t;
  logic clk, rstn, hsel, hwrite, poll, srqc, lkey, ifc, ren, cv;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] cmd, keys, pbyte;
  logic [31:0] hrdata;
  logic hready, hresp, remote_state_indicator, tlk, lsn, lock, srq, pvalid, dclr, trig;
  logic [7:0] keys_g;
  int n_errors, compares, clr_cnt, trg_cnt, pv_cnt, i;
  // CFG writes beside the address field expected back
  gdb_row_t rows [6] = '{'{8'h05, 8'h05}, '{8'h1E, 8'h1E},
    '{8'h1F, 8'h1E}, '{8'h23, 8'h23}, '{8'h3F, 8'h23}, '{8'h0E, 8'h0E}};

  gdb_bus_core dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .CMD_IN(cmd), .CMD_VALID_IN(cv), .IFC_IN(ifc), .REN_IN(ren),
    .POLL_REQ_IN(poll), .SRQ_COND_IN(srqc), .KEYS_IN(keys),
    .LOCAL_KEY_IN(lkey), .KEYS_OUT(keys_g),
    .REMOTE_STATE_INDICATOR_OUT(remote_state_indicator), .TALK_INDICATOR_OUT(tlk),
    .LISTENER_ACTIVE_INDICATOR_OUT(lsn), .LOCKOUT_OUT(lock),
    .SRQ_OUT(srq), .POLL_BYTE_OUT(pbyte), .POLL_VALID_OUT(pvalid),
    .DEV_CLEAR_OUT(dclr), .TRIGGER_OUT(trig));
  gdb_ctl_model ctl (.clk_in(clk), .cmd_out(cmd), .valid_out(cv),
    .ifc_out(ifc), .ren_out(ren), .poll_out(poll));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Pulse counters for clear, trigger and poll strobes
  always @(posedge clk)
  begin
    if (dclr === 1'b1) clr_cnt++;
    if (trig === 1'b1) trg_cnt++;
    if (pvalid === 1'b1) pv_cnt++;
  end

  task complete_run;
    $display("Checks %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bounded wait for hready at a rising edge
  task wait_ready;
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 50)
    begin
      n_errors++;
      $display("BAD hready expected 1 seen %b", hready);
      complete_run();
    end
  endtask : wait_ready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    hsel <= 1'b0;
  endtask : ahb
  // Let a command or line change reach the outputs
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task send_s(input logic [7:0] b);
    ctl.send(b);
    settle();
  endtask : send_s
  task press_local;
    @(posedge clk);
    lkey <= 1'b1;
    @(posedge clk);
    lkey <= 1'b0;
    settle();
  endtask : press_local
  // Service request condition level, changed on a rising edge
  task set_cond(input logic v);
    @(posedge clk);
    srqc <= v;
    settle();
  endtask : set_cond

  // Main sequence
  initial
  begin
    {rstn, hsel, hwrite, srqc, lkey} = 5'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    keys = 8'hA5;
    {n_errors, compares, clr_cnt, trg_cnt, pv_cnt} = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk("ind", 32'h0, {remote_state_indicator, tlk, lsn, lock, srq});
    ahb(1'b0, OFF_CFG, 32'h0);
    chk("cfg_rst", 32'h0E, {26'h0, rd[5:0]});
    ahb(1'b0, OFF_STB, 32'h0);
    chk("stb_rst", 32'h0, {24'h0, rd[7:0]});
    // Address field writes, out of range ones refused
    for (i = 0; i < 6; i++)
    begin
      ahb(1'b1, OFF_CFG, {24'h0, rows[i].wr});
      ahb(1'b0, OFF_CFG, 32'h0);
      chk("cfg", {24'h0, rows[i].exp}, {26'h0, rd[5:0]});
    end
    ahb(1'b0, 8'h0C, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("rd_unmapped", 32'h0, rd);
    // Remote only by listen address while REN high
    ctl.set_ren(1'b1);
    settle();
    chk("rem_ren", 32'h0, {31'h0, remote_state_indicator});
    send_s(8'h4E);
    chk("talk_local", 32'h2, {30'h0, tlk, remote_state_indicator});
    send_s(8'h2E);
    chk("listen", 32'h5, {29'h0, remote_state_indicator, tlk, lsn});
    chk("keys_rem", 32'h0, {24'h0, keys_g});
    press_local();
    chk("rem_loc", 32'h0, {31'h0, remote_state_indicator});
    chk("keys_loc", 32'hA5, {24'h0, keys_g});
    // Lockout then go-to-local
    send_s(8'h2E);
    send_s({1'b0, CMD_LLO});
    press_local();
    chk("llo", 32'h3, {30'h0, remote_state_indicator, lock});
    chk("keys_llo", 32'h0, {24'h0, keys_g});
    send_s({1'b0, CMD_GTL});
    chk("gtl", 32'h0, {30'h0, remote_state_indicator, lock});
    chk("keys_gtl", 32'hA5, {24'h0, keys_g});
    // New primary address applies to following addressing
    ahb(1'b1, OFF_CFG, 32'h05);
    send_s({1'b0, CMD_UNL});
    chk("unl", 32'h0, {31'h0, lsn});
    send_s(8'h2E);
    chk("old_addr", 32'h0, {31'h0, lsn});
    send_s(8'h25);
    chk("new_addr", 32'h1, {31'h0, lsn});
    send_s(8'h45);
    chk("talk", 32'h2, {30'h0, tlk, lsn});
    send_s({1'b0, CMD_UNT});
    chk("unt", 32'h0, {31'h0, tlk});
    // Clears: universal, then selective only when listener
    send_s({1'b0, CMD_DCL});
    chk("dcl", 32'h1, clr_cnt);
    send_s({1'b0, CMD_SDC});
    chk("sdc_idle", 32'h1, clr_cnt);
    send_s(8'h25);
    send_s({1'b0, CMD_SDC});
    chk("sdc", 32'h2, clr_cnt);
    ahb(1'b0, OFF_CFG, 32'h0);
    chk("cfg_dcl", 32'h05, {26'h0, rd[5:0]});
    // Trigger only with bus trigger source selected
    send_s({1'b0, CMD_GET});
    chk("get_off", 32'h0, trg_cnt);
    ahb(1'b1, OFF_CFG, 32'h25);
    send_s({1'b0, CMD_GET});
    chk("get_on", 32'h1, trg_cnt);
    // Serial poll with and without a pending request
    ahb(1'b1, OFF_STB, 32'h81);
    set_cond(1'b1);
    chk("srq", 32'h1, {31'h0, srq});
    send_s({1'b0, CMD_SPE});
    send_s(8'h45);
    ctl.poll();
    settle();
    chk("pbyte_srq", 32'hC1, {24'h0, pbyte});
    chk("pv", 32'h1, pv_cnt);
    chk("srq_polled", 32'h0, {31'h0, srq});
    set_cond(1'b0);
    set_cond(1'b1);
    chk("srq_rise", 32'h1, {31'h0, srq});
    set_cond(1'b0);
    chk("srq_gone", 32'h0, {31'h0, srq});
    ctl.poll();
    settle();
    chk("pbyte", 32'h81, {24'h0, pbyte});
    chk("pv2", 32'h2, pv_cnt);
    ahb(1'b0, OFF_STAT, 32'h0);
    chk("stat", 32'h15, rd);
    send_s({1'b0, CMD_SPD});
    ctl.poll();
    settle();
    chk("spd", 32'h2, pv_cnt);
    // Interface clear idles talker, keeps settings
    chk("tlk_pre", 32'h1, {31'h0, tlk});
    ctl.ifc();
    settle();
    chk("ifc", 32'h0, {30'h0, tlk, lsn});
    ahb(1'b0, OFF_CFG, 32'h0);
    chk("cfg_ifc", 32'h25, {26'h0, rd[5:0]});
    ahb(1'b0, OFF_STB, 32'h0);
    chk("stb_ifc", 32'h81, {24'h0, rd[7:0]});
    ahb(1'b0, OFF_STAT, 32'h0);
    chk("stat_ifc", 32'h01, rd);
    // Another device's talk address idles our talker
    send_s(8'h45);
    chk("tlk_again", 32'h1, {31'h0, tlk});
    send_s(8'h47);
    chk("ota", 32'h0, {31'h0, tlk});
    // Remote enable dropped forces local
    ctl.set_ren(1'b0);
    settle();
    chk("ren_low", 32'h0, {31'h0, remote_state_indicator});
    complete_run();
  end
endmodule : gpib_device_bus_functions_tb
